// ===== pac_pkg.sv
// How it works
// - instruction 5 writes value into axis parameter
// - axis working copy is volatile storage
// - instruction 6 reads; program mode loads accumulator
// - direct mode axis get leaves accumulator untouched
// - instruction 7 copies axis parameter to nonvolatile
// - instruction 8 reloads axis parameter from nonvolatile
// - power up reloads all axis parameters first
// - instruction 9 writes global parameter in bank
// - banks: 0 settings, 2 user, 3 interrupts
// - bank 0 writes also commit to nonvolatile
// - instruction 10 loads global into accumulator
// - get global reply: status 100 plus value
package pac_pkg;
  // instruction codes handled here
  localparam logic [7:0] INSTR_SET_AXIS     = 8'h05;
  localparam logic [7:0] INSTR_GET_AXIS     = 8'h06;
  localparam logic [7:0] INSTR_STORE_AXIS   = 8'h07;
  localparam logic [7:0] INSTR_RESTORE_AXIS = 8'h08;
  localparam logic [7:0] INSTR_SET_GLOBAL   = 8'h09;
  localparam logic [7:0] INSTR_GET_GLOBAL   = 8'h0a;
  // global parameter banks
  localparam logic [7:0] BANK_SETTINGS      = 8'h00;
  localparam logic [7:0] BANK_USER          = 8'h02;
  localparam logic [7:0] BANK_IRQ           = 8'h03;
  // axis commands need motor 0
  localparam logic [7:0] MOTOR_ONLY         = 8'h00;
  // reply status codes
  localparam logic [7:0] STATUS_OK          = 8'h64;
  localparam logic [7:0] STATUS_BAD_VALUE   = 8'h04;
  // frame layout: byte index of the checksum
  localparam logic [3:0] FRAME_LAST         = 4'h8;
  // reset values
  localparam logic [31:0] ACCU_RESET        = 32'h0000_0000;
  localparam logic [7:0]  INDEX_LAST        = 8'hff;
  localparam logic [8:0]  BOOT_CYCLES       = 9'h100;  // reload edges after reset

  // true for the three banks that exist
  function automatic logic bank_ok(input logic [7:0] bank);
    bank_ok = (bank == BANK_SETTINGS) || (bank == BANK_USER) || (bank == BANK_IRQ);
  endfunction
endpackage

// ===== pac_frame_if.sv
// one decoded command frame, valid for a single cycle
interface pac_frame_if;
  logic        valid;  // frame complete with good checksum
  logic [7:0]  addr;   // target address
  logic [7:0]  instr;  // instruction code
  logic [7:0]  ptype;  // parameter number
  logic [7:0]  bank;   // motor or bank
  logic [31:0] value;  // value, assembled msb first
  modport rx   (output valid, output addr, output instr, output ptype,
                output bank, output value);
  modport core (input valid, input addr, input instr, input ptype,
                input bank, input value);
endinterface

// ===== pac_frame_rx.sv
module pac_frame_rx
  import pac_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // byte stream from the link logic
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // decoded frame
  pac_frame_if.rx          frame
);
  logic [3:0]  count_q;    // byte position within the frame
  logic [7:0]  sum_q;      // running checksum of bytes 0..7
  logic [7:0]  addr_q;     // captured target address
  logic [7:0]  instr_q;    // captured instruction
  logic [7:0]  ptype_q;    // captured type
  logic [7:0]  bank_q;     // captured motor or bank
  logic [31:0] value_q;    // value shifted in msb first
  logic        valid_q;    // one-cycle frame strobe

  // byte counter and checksum; no resync on gaps, so the link must
  // deliver whole frames or be reset to realign
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= 4'h0;
      sum_q   <= 8'h00;
    end else if (rx_valid) begin
      if (count_q == FRAME_LAST) begin
        count_q <= 4'h0;  // checksum byte closes the frame
        sum_q   <= 8'h00;
      end else begin
        count_q <= count_q + 4'h1;
        sum_q   <= sum_q + rx_byte;  // low eight bits of the sum
      end
    end
  end

  // field capture by byte position
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addr_q  <= 8'h00;
      instr_q <= 8'h00;
      ptype_q <= 8'h00;
      bank_q  <= 8'h00;
      value_q <= 32'h0000_0000;
    end else if (rx_valid) begin
      case (count_q)
        4'h0: addr_q  <= rx_byte;
        4'h1: instr_q <= rx_byte;
        4'h2: ptype_q <= rx_byte;
        4'h3: bank_q  <= rx_byte;
        4'h4, 4'h5, 4'h6, 4'h7: value_q <= {value_q[23:0], rx_byte};  // msb first
        default: ;  // checksum byte stores nothing
      endcase
    end
  end

  // strobe only when the checksum agrees; bad frames vanish silently
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= rx_valid && (count_q == FRAME_LAST) && (rx_byte == sum_q);
    end
  end

  assign frame.valid = valid_q;
  assign frame.addr  = addr_q;
  assign frame.instr = instr_q;
  assign frame.ptype = ptype_q;
  assign frame.bank  = bank_q;
  assign frame.value = value_q;

  checksum_match_a: assert property (@(posedge clock) disable iff (reset)
    valid_q |-> $past(rx_valid) && ($past(rx_byte) == $past(sum_q)))
    else $error("frame strobe without matching checksum");
  count_bound_a: assert property (@(posedge clock) disable iff (reset)
    count_q <= FRAME_LAST)
    else $error("byte counter ran past the checksum byte");
endmodule

// ===== pac_top.sv
module pac_top
  import pac_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // command bytes from the link logic, same clock
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // configuration and mode from the surrounding logic
  input  wire logic [7:0]  dev_address,
  input  wire logic        run_program,
  // reply towards the host
  output logic             reply_valid,
  output logic [7:0]       reply_instr,
  output logic [7:0]       reply_status,
  output logic [31:0]      reply_value,
  // accumulator and status
  output logic [31:0]      accu_value,
  output logic             ready,
  output logic             nv_write
);
  // controller states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,  // reloading from nonvolatile storage
    ST_IDLE = 2'b10   // accepting frames
  } pac_state_e;

  pac_state_e  state_q;          // controller state
  logic [7:0]  boot_idx_q;       // parameter index during reload
  logic        reply_valid_q;    // reply strobe
  logic [7:0]  reply_instr_q;    // echoed instruction
  logic [7:0]  reply_status_q;   // reply status
  logic [31:0] reply_value_q;    // reply value
  logic [31:0] accu_q;           // accumulator register
  logic        nv_write_q;       // one-cycle marker of a nonvolatile write
  logic        ready_q;          // set once the reload is done
  logic [8:0]  boot_cycles_q;    // edges spent reloading, for the checks only

  // working and nonvolatile stores; nonvolatile arrays get no reset
  // since they stand for storage that survives a power cycle
  logic [31:0] axis_ram  [0:255];  // volatile axis parameters
  logic [31:0] axis_nv   [0:255];  // stored axis parameters
  logic [31:0] glob_ram  [0:255];  // bank 0 working copy
  logic [31:0] glob_nv   [0:255];  // bank 0 stored copy
  logic [31:0] user_ram  [0:255];  // bank 2 user variables
  logic [31:0] irq_ram   [0:255];  // bank 3 interrupt configuration

  // decode results
  logic        exec_go;     // frame for us, controller idle
  logic        is_axis;     // instructions 5..8
  logic        is_global;   // instructions 9 and 10
  logic        args_ok;     // motor or bank field legal
  logic [31:0] rd_value;    // read data for get instructions

  pac_frame_if frame ();

  // frame assembly and checksum check
  pac_frame_rx u_rx (
    .clock    (clock),
    .reset    (reset),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .frame    (frame)
  );

  // command decode; frames arriving during boot reload are dropped
  always_comb begin
    exec_go   = (state_q == ST_IDLE) && frame.valid
                && (frame.addr == dev_address);
    is_axis   = (frame.instr == INSTR_SET_AXIS) || (frame.instr == INSTR_GET_AXIS)
                || (frame.instr == INSTR_STORE_AXIS) || (frame.instr == INSTR_RESTORE_AXIS);
    is_global = (frame.instr == INSTR_SET_GLOBAL) || (frame.instr == INSTR_GET_GLOBAL);
    if (is_axis) begin
      args_ok = (frame.bank == MOTOR_ONLY);  // single axis module
    end else begin
      args_ok = bank_ok(frame.bank);
    end
  end

  // read data: axis store or the addressed bank
  always_comb begin
    if (frame.instr == INSTR_GET_AXIS) begin
      rd_value = axis_ram[frame.ptype];
    end else begin
      case (frame.bank)
        BANK_SETTINGS: rd_value = glob_ram[frame.ptype];
        BANK_USER:     rd_value = user_ram[frame.ptype];
        BANK_IRQ:      rd_value = irq_ram[frame.ptype];
        default:       rd_value = 32'h0000_0000;
      endcase
    end
  end

  // state machine: reload every axis and bank 0 parameter once, then serve frames
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q    <= ST_BOOT;
      boot_idx_q <= 8'h00;
    end else begin
      case (state_q)
        ST_BOOT: begin
          boot_idx_q <= boot_idx_q + 8'h01;
          if (boot_idx_q == INDEX_LAST) begin
            state_q <= ST_IDLE;  // all 256 reloaded
          end
        end
        ST_IDLE: state_q <= ST_IDLE;
        default: state_q <= ST_BOOT;
      endcase
    end
  end

  // ready in its own flop so the port is a plain register output
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else if ((state_q == ST_BOOT) && (boot_idx_q == INDEX_LAST)) begin
      ready_q <= 1'b1;  // set with the last reload
    end
  end

  // independent count of reload edges, so a broken index counter shows up
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boot_cycles_q <= 9'h000;
    end else if (!ready_q) begin
      boot_cycles_q <= boot_cycles_q + 9'h001;
    end
  end

  // axis stores: boot reload, set, store and restore
  always_ff @(posedge clock) begin
    if (state_q == ST_BOOT) begin
      axis_ram[boot_idx_q] <= axis_nv[boot_idx_q];
    end else if (exec_go && args_ok) begin
      case (frame.instr)
        INSTR_SET_AXIS:     axis_ram[frame.ptype] <= frame.value;
        INSTR_STORE_AXIS:   axis_nv[frame.ptype]  <= axis_ram[frame.ptype];
        INSTR_RESTORE_AXIS: axis_ram[frame.ptype] <= axis_nv[frame.ptype];
        default: ;
      endcase
    end
  end

  // global stores; bank 0 writes go to both copies at once, so no
  // separate store command is ever needed for settings
  always_ff @(posedge clock) begin
    if (state_q == ST_BOOT) begin
      glob_ram[boot_idx_q] <= glob_nv[boot_idx_q];
    end else if (exec_go && args_ok && (frame.instr == INSTR_SET_GLOBAL)) begin
      case (frame.bank)
        BANK_SETTINGS: begin
          glob_ram[frame.ptype] <= frame.value;
          glob_nv[frame.ptype]  <= frame.value;
        end
        BANK_USER: user_ram[frame.ptype] <= frame.value;
        BANK_IRQ:  irq_ram[frame.ptype]  <= frame.value;
        default: ;
      endcase
    end
  end

  // nonvolatile write marker for observers of the storage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      nv_write_q <= 1'b0;
    end else begin
      nv_write_q <= exec_go && args_ok
                    && ((frame.instr == INSTR_STORE_AXIS)
                        || ((frame.instr == INSTR_SET_GLOBAL)
                            && (frame.bank == BANK_SETTINGS)));
    end
  end

  // accumulator: global gets always, axis gets only in program mode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      accu_q <= ACCU_RESET;
    end else if (exec_go && args_ok) begin
      if (frame.instr == INSTR_GET_GLOBAL) begin
        accu_q <= rd_value;
      end else if ((frame.instr == INSTR_GET_AXIS) && run_program) begin
        accu_q <= rd_value;
      end
      // direct mode axis get keeps the old accumulator
    end
  end

  // reply: only for instructions of this group; others belong elsewhere
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reply_valid_q  <= 1'b0;
      reply_instr_q  <= 8'h00;
      reply_status_q <= 8'h00;
      reply_value_q  <= 32'h0000_0000;
    end else begin
      reply_valid_q <= exec_go && (is_axis || is_global);
      if (exec_go && (is_axis || is_global)) begin
        reply_instr_q <= frame.instr;
        if (!args_ok) begin
          reply_status_q <= STATUS_BAD_VALUE;  // illegal motor or bank
          reply_value_q  <= 32'h0000_0000;
        end else if ((frame.instr == INSTR_GET_AXIS)
                     || (frame.instr == INSTR_GET_GLOBAL)) begin
          reply_status_q <= STATUS_OK;
          reply_value_q  <= rd_value;
        end else begin
          reply_status_q <= STATUS_OK;  // value carries no meaning
          reply_value_q  <= 32'h0000_0000;
        end
      end
    end
  end

  assign reply_valid  = reply_valid_q;
  assign reply_instr  = reply_instr_q;
  assign reply_status = reply_status_q;
  assign reply_value  = reply_value_q;
  assign accu_value   = accu_q;
  assign ready        = ready_q;
  assign nv_write     = nv_write_q;

  set_reply_ok_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && ((frame.instr == INSTR_SET_AXIS)
      || (frame.instr == INSTR_STORE_AXIS) || (frame.instr == INSTR_SET_GLOBAL)))
    |=> reply_valid_q && (reply_status_q == STATUS_OK))
    else $error("set or store not answered with status ok");
  gap_direct_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_GET_AXIS) && !run_program)
    |=> $stable(accu_q) && (reply_value_q == $past(rd_value)))
    else $error("direct axis get disturbed the accumulator");
  gap_program_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_GET_AXIS) && run_program)
    |=> (accu_q == $past(rd_value)))
    else $error("program axis get did not load accumulator");
  ggp_accu_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_GET_GLOBAL))
    |=> (accu_q == reply_value_q) && (reply_status_q == STATUS_OK))
    else $error("global get did not fill accumulator and reply");
  bank0_commit_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && (frame.instr == INSTR_SET_GLOBAL) && (frame.bank == BANK_SETTINGS))
    |=> nv_write_q)
    else $error("bank 0 write not committed");
  user_volatile_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && ((frame.instr == INSTR_SET_AXIS)
      || ((frame.instr == INSTR_SET_GLOBAL) && (frame.bank != BANK_SETTINGS))))
    |=> !nv_write_q)
    else $error("volatile write touched nonvolatile store");
  boot_quiet_a: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_BOOT) |=> !reply_valid_q)
    else $error("reply issued during boot reload");
  foreign_addr_a: assert property (@(posedge clock) disable iff (reset)
    (frame.valid && (frame.addr != dev_address)) |=> !reply_valid_q)
    else $error("frame for another address answered");
  bad_bank_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && is_global && !bank_ok(frame.bank))
    |=> (reply_status_q == STATUS_BAD_VALUE) && !nv_write_q)
    else $error("illegal bank accepted");
  user_bank_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_SET_GLOBAL) && (frame.bank == BANK_USER))
    |=> (user_ram[$past(frame.ptype)] == $past(frame.value)))
    else $error("user variable write did not land");

  // checks on the boot reload
  ready_state_a: assert property (@(posedge clock) disable iff (reset)
    ready_q == (state_q == ST_IDLE))
    else $error("ready flag and controller state disagree");
  boot_len_a: assert property (@(posedge clock) disable iff (reset)
    $rose(ready_q) |-> (boot_cycles_q == BOOT_CYCLES))
    else $error("reload did not take one edge per parameter");
  state_onehot_a: assert property (@(posedge clock) disable iff (reset)
    $onehot(state_q))
    else $error("controller state not one-hot");

  // checks on axis commands, the accumulator and the reply strobe
  set_axis_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_SET_AXIS))
    |=> (axis_ram[$past(frame.ptype)] == $past(frame.value)))
    else $error("axis set did not land");
  store_nv_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_STORE_AXIS))
    |=> (axis_nv[$past(frame.ptype)] == $past(axis_ram[frame.ptype])))
    else $error("axis store did not reach the stored copy");
  restore_axis_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && args_ok && (frame.instr == INSTR_RESTORE_AXIS))
    |=> (axis_ram[$past(frame.ptype)] == $past(axis_nv[frame.ptype])))
    else $error("axis restore did not reload the working copy");
  motor_refused_a: assert property (@(posedge clock) disable iff (reset)
    (exec_go && is_axis && (frame.bank != MOTOR_ONLY))
    |=> (reply_status_q == STATUS_BAD_VALUE) && $stable(accu_q))
    else $error("axis command for a missing motor accepted");
  accu_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(exec_go && args_ok) |=> $stable(accu_q))
    else $error("accumulator moved without a command");
  reply_pulse_a: assert property (@(posedge clock) disable iff (reset)
    reply_valid_q |=> !reply_valid_q)
    else $error("reply strobe longer than one cycle");
endmodule

// ===== pac_host_model.sv
// host side of the link: sends whole command frames, one byte per cycle
module pac_host_model (
  // clock from the bench
  input  wire logic clock,
  // byte stream towards the device
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle link at time zero
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  // one nine byte frame, driven off the sampling edge
  task automatic send_frame(input logic [7:0] addr, input logic [7:0] instr,
      input logic [7:0] ptype, input logic [7:0] bank, input logic [31:0] value,
      input logic bad_sum);
    logic [7:0] b [9];
    logic [7:0] sum;
    b = '{addr, instr, ptype, bank, value[31:24], value[23:16], value[15:8],
          value[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum + b[i];
    end
    // a broken checksum is only sent when a test asks for one
    b[8] = bad_sum ? ~sum : sum;
    for (int i = 0; i < 9; i++) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_byte  = b[i];
    end
    @(negedge clock);
    rx_valid = 1'b0;
    // released data lines must not keep showing the last byte
    rx_byte  = ~rx_byte;
  endtask
endmodule

// ===== test_parameter_access_commands.sv
module test_parameter_access_commands import pac_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  // design inputs and outputs
  logic        clock;
  logic        reset;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  dev_address;
  logic        run_program;
  logic        reply_valid;
  logic [7:0]  reply_instr;
  logic [7:0]  reply_status;
  logic [31:0] reply_value;
  logic [31:0] accu_value;
  logic        ready;
  logic        nv_write;
  // bookkeeping
  int          miscompares;
  int          total_checks;
  // reference model: working copy, nonvolatile copy, globals by bank*256+type
  logic [31:0] m_ram [int];
  logic [31:0] m_nv [int];
  logic [31:0] m_gl [int];
  logic [31:0] m_gnv [int];
  logic [31:0] m_accu;
  logic [7:0]  ta;
  logic [7:0]  tg;
  logic [31:0] va;

  pac_top i_pac_top (.clock(clock), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .dev_address(dev_address), .run_program(run_program), .reply_valid(reply_valid),
    .reply_instr(reply_instr), .reply_status(reply_status), .reply_value(reply_value),
    .accu_value(accu_value), .ready(ready), .nv_write(nv_write));
  pac_host_model i_pac_host_model (.clock(clock), .rx_valid(rx_valid), .rx_byte(rx_byte));

  // 100 ns period
  initial begin
    clock = 1'b0;
  end
  always #50 clock = ~clock;

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // model of power up, then bounded wait for the reload to finish
  task automatic boot_check();
    foreach (m_nv[k]) m_ram[k] = m_nv[k];
    foreach (m_gnv[k]) m_gl[k] = m_gnv[k];
    m_accu = ACCU_RESET;
    repeat (200) @(negedge clock);
    chk("ready early", ready, 32'h0);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) begin
      @(negedge clock);
    end
    chk("ready", ready, 32'h1);
    chk("accu after reset", accu_value, m_accu);
  endtask

  // kind 0 good frame, 1 bad checksum, 2 foreign address, 3 frame to be dropped
  task automatic do_cmd(input logic [7:0] ins, input logic [7:0] t, input logic [7:0] bk,
      input logic [31:0] v, input int kind);
    logic [7:0]  st;
    logic [31:0] ev;
    logic        nvw;
    logic        seen;
    int          key;
    st = STATUS_OK;
    ev = 32'h0;
    nvw = 1'b0;
    seen = 1'b0;
    key = bk * 256 + t;
    // axis commands need motor 0, global ones an existing bank
    if ((ins < 8'h09 && bk != 8'h00) ||
        (ins >= 8'h09 && bk != 8'h00 && bk != 8'h02 && bk != 8'h03)) begin
      st = STATUS_BAD_VALUE;
    end else if (kind == 0) begin
      case (ins)
        INSTR_SET_AXIS: m_ram[t] = v;
        INSTR_GET_AXIS: begin
          ev = m_ram[t];
          if (run_program) m_accu = ev;
        end
        INSTR_STORE_AXIS: begin
          m_nv[t] = m_ram[t];
          nvw = 1'b1;
        end
        INSTR_RESTORE_AXIS: m_ram[t] = m_nv[t];
        INSTR_SET_GLOBAL: begin
          m_gl[key] = v;
          if (bk == 8'h00) begin
            m_gnv[t] = v;
            nvw = 1'b1;
          end
        end
        default: begin
          ev = m_gl[key];
          m_accu = ev;
        end
      endcase
    end
    i_pac_host_model.send_frame(kind == 2 ? dev_address ^ 8'h01 : dev_address, ins, t, bk, v,
                                kind == 1);
    for (int i = 0; i < 6 && !seen; i++) begin
      if (reply_valid === 1'b1) begin
        seen = 1'b1;
        chk("instr", reply_instr, ins);
        chk("status", reply_status, st);
        chk("value", reply_value, ev);
        chk("accu", accu_value, m_accu);
        chk("nv_write", nv_write, nvw);
      end else begin
        @(negedge clock);
      end
    end
    chk("reply seen", seen, kind == 0);
    @(negedge clock);
    chk("reply pulse", reply_valid, 32'h0);
    chk("nv pulse", nv_write, 32'h0);
  endtask

  // watchdog, far beyond the expected run of about a thousand cycles
  initial begin
    #2000000;
    miscompares++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    dev_address = 8'h00;
    run_program = 1'b0;
    miscompares = 0;
    total_checks = 0;
    va = $urandom(3);
    repeat (6) @(negedge clock);
    dev_address = 8'($urandom % 256);
    reset = 1'b0;
    boot_check();
    $display("test boot done");
    // axis set, get, store, overwrite, restore
    for (int k = 0; k < 3; k++) begin
      ta = 8'($urandom % 256);
      va = $urandom;
      do_cmd(INSTR_SET_AXIS, ta, 8'h00, va, 0);
      do_cmd(INSTR_GET_AXIS, ta, 8'h00, 32'h0, 0);
      do_cmd(INSTR_STORE_AXIS, ta, 8'h00, $urandom, 0);
      do_cmd(INSTR_SET_AXIS, ta, 8'h00, ~va, 0);
      do_cmd(INSTR_RESTORE_AXIS, ta, 8'h00, $urandom, 0);
      do_cmd(INSTR_GET_AXIS, ta, 8'h00, 32'h0, 0);
    end
    run_program = 1'b1;
    do_cmd(INSTR_GET_AXIS, ta, 8'h00, 32'h0, 0);
    run_program = 1'b0;
    $display("test axis done");
    // every bank written then read back into the accumulator
    tg = 8'($urandom % 256);
    for (int j = 0; j < 3; j++) begin
      do_cmd(INSTR_SET_GLOBAL, tg, 8'(j == 0 ? 0 : j + 1), $urandom, 0);
      do_cmd(INSTR_GET_GLOBAL, tg, 8'(j == 0 ? 0 : j + 1), $urandom, 0);
    end
    $display("test globals done");
    // illegal motor or bank, broken checksum, foreign address
    do_cmd(INSTR_SET_AXIS, ta, 8'h01, $urandom, 0);
    do_cmd(INSTR_SET_GLOBAL, tg, 8'h01, $urandom, 0);
    do_cmd(INSTR_SET_AXIS, ta, 8'h00, $urandom, 1);
    do_cmd(INSTR_SET_AXIS, ta, 8'h00, $urandom, 2);
    do_cmd(8'h02, ta, 8'h00, $urandom, 3);
    do_cmd(INSTR_GET_AXIS, ta, 8'h00, 32'h0, 0);
    $display("test refusals done");
    // working copy is lost over a reset, nonvolatile copies come back
    do_cmd(INSTR_SET_AXIS, ta, 8'h00, $urandom, 0);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    do_cmd(INSTR_SET_AXIS, ta, 8'h00, $urandom, 3);
    boot_check();
    do_cmd(INSTR_GET_AXIS, ta, 8'h00, 32'h0, 0);
    do_cmd(INSTR_GET_GLOBAL, tg, 8'h00, 32'h0, 0);
    $display("test reset done");
    end_of_test();
  end
endmodule
